// ===== core/boot_cfg_pkg.sv
// Operation
// - Isolation input low during reset is latched when reset rises.
// - While isolated, the fail pin and bus pins are left undriven and no fetch is made.
// - Twelve-word boot record is fetched from the fixed top address.
// - Low bytes of words 0..2 fill region-0 config, lowest first.
// - Word 4 of the boot record is reserved zero and never loaded.
// - Region table valid clears at init; all requests use region 0.
// - Region-0 config is preset to the most relaxed bus settings first.
// - First byte applies at once; bytes 1-2 use new waits, then rewrite.
// - Load first instruction pointer, control block pointer, six sums.
// - Pointers, six sums and all-ones must add to zero to pass.
// - After passing, cache control block, NMI entry, supervisor stack.
// - Load remaining region table and global config; valid bit applies.
// - Base addresses are cached until reset or reinitialization.
// - Arithmetic controls image is copied into the controls register.
// - Fault config bit 30 set masks the unaligned fault.
// - Cache config bit 16 set disables the instruction cache.
// - Cache stays off until reinit or an enabling control command.
// - Low four bits give cached register sets; above five use RAM.
// - A call on a full register cache spills the oldest set.
// - Fail output low during each self test, released on bus pass.
// - Internal test enable is sampled when reset rises.
package boot_cfg_pkg;

  localparam logic [31:0] IBR_BASE = 32'hFFFF_FF00;
  localparam logic [4:0] IBR_CFG2_IDX = 5'h02;
  localparam logic [4:0] IBR_IP_IDX = 5'h03;
  localparam logic [4:0] IBR_RSVD_IDX = 5'h04;
  localparam logic [4:0] IBR_PRCB_IDX = 5'h05;
  localparam logic [4:0] IBR_LAST_IDX = 5'h0B;
  localparam logic [31:0] CHECKSUM_SEED = 32'hFFFF_FFFF;

  // Region configuration field positions
  localparam int RD_ADDR_WAIT_LSB = 3;
  localparam int RD_DATA_WAIT_LSB = 8;
  localparam int TURN_WAIT_LSB = 10;
  localparam int WR_ADDR_WAIT_LSB = 12;
  localparam int WR_DATA_WAIT_LSB = 17;
  localparam logic [31:0] MC_RELAXED = (32'h0000_001F << RD_ADDR_WAIT_LSB)
    | (32'h0000_0003 << RD_DATA_WAIT_LSB)
    | (32'h0000_0003 << TURN_WAIT_LSB)
    | (32'h0000_001F << WR_ADDR_WAIT_LSB)
    | (32'h0000_0003 << WR_DATA_WAIT_LSB);
  localparam int TBL_VALID_BIT = 0;

  // Control block word indices
  localparam logic [4:0] PRCB_FAULT_TBL = 5'h00;
  localparam logic [4:0] PRCB_CTL_TBL = 5'h01;
  localparam logic [4:0] PRCB_ARITH = 5'h02;
  localparam logic [4:0] PRCB_FAULT_CFG = 5'h03;
  localparam logic [4:0] PRCB_INTR_TBL = 5'h04;
  localparam logic [4:0] PRCB_SYSPROC = 5'h05;
  localparam logic [4:0] PRCB_ISTACK = 5'h07;
  localparam logic [4:0] PRCB_ICACHE = 5'h08;
  localparam logic [4:0] PRCB_RCACHE = 5'h09;
  localparam int UNALIGNED_OK_BIT = 30;
  localparam int ICACHE_OFF_BIT = 16;
  localparam logic [3:0] RCACHE_FREE_SETS = 4'h5;
  localparam logic [31:0] SSP_OFFSET = 32'h0000_000C;
  localparam logic [31:0] NMI_OFFSET = 32'h0000_0024;
  localparam logic [31:0] SP_OFFSET = 32'h0000_0040;
  localparam logic [4:0] CTL_FIRST_IDX = 5'h01;
  localparam logic [4:0] CTL_GLOBAL_IDX = 5'h10;
  localparam logic [7:0] ITEST_CYCLES = 8'h40;

  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_REINIT_PRCB = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_REGION0 = 8'h0C;
  localparam logic [7:0] REG_BUS_GLOBAL = 8'h10;
  localparam logic [7:0] REG_FIRST_IP = 8'h14;
  localparam logic [7:0] REG_PRCB_PTR = 8'h18;
  localparam logic [7:0] REG_ARITH = 8'h1C;
  localparam logic [7:0] REG_FRAME_PTR = 8'h20;
  localparam logic [7:0] REG_STACK_PTR = 8'h24;
  localparam logic [7:0] REG_NMI_VEC = 8'h28;
  localparam logic [7:0] REG_SUP_STACK = 8'h2C;
  localparam int CTRL_REINIT = 0;
  localparam int CTRL_ICACHE_ON = 1;
  localparam int ST_DONE = 0;
  localparam int ST_HALT = 1;
  localparam int ST_ISOL = 2;
  localparam int ST_ITEST = 3;
  localparam int ST_TBL_VALID = 4;
  localparam int ST_ICOFF = 5;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] bus_cfg;
  } mem_req_s;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } mem_rsp_s;

endpackage

// ===== core/boot_config_loader.sv
`timescale 1ns/1ps
module boot_config_loader (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Straps
  input wire logic isolate_n_i,
  input wire logic internal_test_enable_i,
  // Pin drive
  output logic fail_n_o,
  output logic fail_oe_o,
  output logic bus_oe_o,
  // Boot memory
  output boot_cfg_pkg::mem_req_s mem_req_o,
  input wire boot_cfg_pkg::mem_rsp_s mem_rsp_i,
  // Register cache
  input wire logic call_i,
  input wire logic ret_i,
  output logic spill_o,
  // Configuration state
  output logic [31:0] region0_bus_config_o,
  output logic region_table_valid_o,
  output logic unaligned_fault_en_o,
  output logic icache_disable_o,
  output logic [31:0] arith_ctl_image_o,
  output logic [3:0] reg_cache_sets_o,
  output logic reg_cache_in_ram_o,
  output logic init_done_o,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o
);
  import boot_cfg_pkg::*;

  typedef enum logic [3:0] {
    S_START, S_ISOLATED, S_ITEST, S_GAP, S_IBR, S_PRCB,
    S_NMI, S_SSP, S_CTL, S_READY, S_HALT
  } load_state_e;

  load_state_e state_reg;
  logic [4:0] idx_reg;
  logic [7:0] test_cnt_reg;
  logic isolate_reg;
  logic test_en_reg;
  logic fail_n_reg;
  logic [31:0] region0_reg;
  logic [7:0] cfg_byte1_reg;
  logic [31:0] region_tbl [1:15];
  logic [31:0] bus_global_reg;
  logic tbl_valid_reg;
  logic [31:0] sum_reg;
  logic [31:0] first_ip_reg;
  logic [31:0] prcb_ptr_reg;
  logic [31:0] fault_tbl_reg;
  logic [31:0] ctl_tbl_reg;
  logic [31:0] arith_reg;
  logic [31:0] fault_cfg_reg;
  logic [31:0] intr_tbl_reg;
  logic [31:0] sysproc_reg;
  logic [31:0] frame_ptr_reg;
  logic [31:0] stack_ptr_reg;
  logic [31:0] nmi_vec_reg;
  logic [31:0] sup_stack_reg;
  logic [31:0] rcache_cfg_reg;
  logic icache_off_reg;
  logic [3:0] occ_reg;
  logic spill_reg;
  logic [31:0] reinit_prcb_reg;
  logic ahb_wr_reg;
  logic [7:0] ahb_addr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_word;
  logic [31:0] status_word;
  logic [31:0] sum_next;
  logic rsp_ok;
  logic ahb_go;
  logic ctrl_wr;
  logic reinit_req;
  logic icache_on_req;
  logic [3:0] rc_sets;

  // Regions other than 0 apply only once the table is valid
  function automatic logic [31:0] sel_cfg(input logic [31:0] addr,
                                          input logic valid_tbl,
                                          input logic [31:0] r0,
                                          input logic [31:0] rn);
    if (valid_tbl && (addr[31:28] != 4'h0)) begin
      return rn;
    end
    return r0;
  endfunction

  assign rsp_ok = mem_req_o.valid && mem_rsp_i.valid;
  assign sum_next = sum_reg + mem_rsp_i.data;
  assign ahb_go = hsel_i && htrans_i[1] && hready_i;
  assign ctrl_wr = ahb_wr_reg && (ahb_addr_reg == REG_CTRL);
  assign reinit_req = ctrl_wr && hwdata_i[CTRL_REINIT];
  assign icache_on_req = ctrl_wr && hwdata_i[CTRL_ICACHE_ON];
  assign rc_sets = rcache_cfg_reg[3:0];

  // Fetch address per phase; requests go out in index order
  always_comb begin
    mem_req_o.valid = 1'b0;
    mem_req_o.addr = IBR_BASE;
    case (state_reg)
      S_IBR: begin
        mem_req_o.valid = 1'b1;
        mem_req_o.addr = IBR_BASE + {25'h0, idx_reg, 2'b00};
      end
      S_PRCB: begin
        mem_req_o.valid = 1'b1;
        mem_req_o.addr = prcb_ptr_reg + {25'h0, idx_reg, 2'b00};
      end
      S_NMI: begin
        mem_req_o.valid = 1'b1;
        mem_req_o.addr = intr_tbl_reg + NMI_OFFSET;
      end
      S_SSP: begin
        mem_req_o.valid = 1'b1;
        mem_req_o.addr = sysproc_reg + SSP_OFFSET;
      end
      S_CTL: begin
        mem_req_o.valid = 1'b1;
        mem_req_o.addr = ctl_tbl_reg + {25'h0, idx_reg, 2'b00};
      end
      default: begin
        mem_req_o.valid = 1'b0;
      end
    endcase
    mem_req_o.bus_cfg = sel_cfg(mem_req_o.addr, tbl_valid_reg, region0_reg,
      region_tbl[mem_req_o.addr[31:28] == 4'h0 ? 4'h1
                 : mem_req_o.addr[31:28]]);
  end

  // Straps follow the pins throughout reset; the last sample holds
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      isolate_reg <= !isolate_n_i;
      test_en_reg <= internal_test_enable_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= S_START;
    end else begin
      case (state_reg)
        S_START: begin
          state_reg <= isolate_reg ? S_ISOLATED : S_ITEST;
        end
        S_ITEST: begin
          if (test_cnt_reg == 8'h00) begin
            state_reg <= S_GAP;
          end
        end
        S_GAP: begin
          state_reg <= S_IBR;
        end
        S_IBR: begin
          if (rsp_ok && (idx_reg == IBR_LAST_IDX)) begin
            state_reg <= (sum_next == 32'h0000_0000) ? S_PRCB : S_HALT;
          end
        end
        S_PRCB: begin
          if (rsp_ok && (idx_reg == PRCB_RCACHE)) begin
            state_reg <= S_NMI;
          end
        end
        S_NMI: begin
          if (rsp_ok) begin
            state_reg <= S_SSP;
          end
        end
        S_SSP: begin
          if (rsp_ok) begin
            state_reg <= S_CTL;
          end
        end
        S_CTL: begin
          if (rsp_ok && (idx_reg == CTL_GLOBAL_IDX)) begin
            state_reg <= S_READY;
          end
        end
        S_READY: begin
          if (reinit_req) begin
            state_reg <= S_PRCB;
          end
        end
        default: begin
          state_reg <= state_reg;
        end
      endcase
    end
  end

  // Word index: ascending, one step per completed fetch; boot record skips word 4
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      idx_reg <= 5'h00;
    end else if (state_reg == S_READY || state_reg == S_GAP) begin
      idx_reg <= 5'h00;
    end else if (rsp_ok) begin
      if (state_reg == S_IBR && idx_reg == IBR_IP_IDX) begin
        idx_reg <= IBR_PRCB_IDX;
      end else if (state_reg == S_SSP) begin
        idx_reg <= CTL_FIRST_IDX;
      end else if (state_reg == S_IBR && idx_reg == IBR_LAST_IDX) begin
        idx_reg <= 5'h00;
      end else begin
        idx_reg <= idx_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      test_cnt_reg <= 8'h00;
    end else if (state_reg == S_START) begin
      test_cnt_reg <= test_en_reg ? ITEST_CYCLES - 8'h01 : 8'h00;
    end else if (test_cnt_reg != 8'h00) begin
      test_cnt_reg <= test_cnt_reg - 8'h01;
    end
  end

  // Fail pin: low in each test, high between them and after a pass
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fail_n_reg <= 1'b0;
    end else if (state_reg == S_ITEST && test_cnt_reg == 8'h00) begin
      fail_n_reg <= 1'b1;
    end else if (state_reg == S_GAP) begin
      fail_n_reg <= 1'b0;
    end else if (state_reg == S_IBR && rsp_ok
                 && idx_reg == IBR_LAST_IDX) begin
      fail_n_reg <= (sum_next == 32'h0000_0000);
    end
  end

  // Region-0 bootstrap and table valid handling
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      region0_reg <= MC_RELAXED;
      cfg_byte1_reg <= 8'h00;
      tbl_valid_reg <= 1'b0;
    end else if (state_reg == S_START) begin
      region0_reg <= MC_RELAXED;
      tbl_valid_reg <= 1'b0;
    end else if (state_reg == S_READY && reinit_req) begin
      tbl_valid_reg <= 1'b0;
    end else if (state_reg == S_IBR && rsp_ok) begin
      if (idx_reg == 5'h00) begin
        region0_reg[7:0] <= mem_rsp_i.data[7:0];
      end else if (idx_reg == 5'h01) begin
        cfg_byte1_reg <= mem_rsp_i.data[7:0];
      end else if (idx_reg == IBR_CFG2_IDX) begin
        region0_reg <= {8'h00, mem_rsp_i.data[7:0], cfg_byte1_reg,
                        region0_reg[7:0]};
      end
    end else if (state_reg == S_CTL && rsp_ok
                 && idx_reg == CTL_GLOBAL_IDX) begin
      tbl_valid_reg <= mem_rsp_i.data[TBL_VALID_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bus_global_reg <= 32'h0000_0000;
    end else if (state_reg == S_CTL && rsp_ok
                 && idx_reg == CTL_GLOBAL_IDX) begin
      bus_global_reg <= mem_rsp_i.data;
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < 16; gi++) begin : g_region
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          region_tbl[gi] <= MC_RELAXED;
        end else if (state_reg == S_CTL && rsp_ok
                     && idx_reg == 5'(gi)) begin
          region_tbl[gi] <= mem_rsp_i.data;
        end
      end
    end
  endgenerate

  // Bus confidence checksum and boot pointers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sum_reg <= CHECKSUM_SEED;
      first_ip_reg <= 32'h0000_0000;
      prcb_ptr_reg <= 32'h0000_0000;
    end else if (state_reg == S_GAP) begin
      sum_reg <= CHECKSUM_SEED;
    end else if (state_reg == S_READY && reinit_req) begin
      prcb_ptr_reg <= reinit_prcb_reg;
    end else if (state_reg == S_IBR && rsp_ok
                 && idx_reg >= IBR_IP_IDX) begin
      sum_reg <= sum_next;
      if (idx_reg == IBR_IP_IDX) begin
        first_ip_reg <= mem_rsp_i.data;
      end
      if (idx_reg == IBR_PRCB_IDX) begin
        prcb_ptr_reg <= mem_rsp_i.data;
      end
    end
  end

  // Control block caching
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fault_tbl_reg <= 32'h0000_0000;
      ctl_tbl_reg <= 32'h0000_0000;
      arith_reg <= 32'h0000_0000;
      fault_cfg_reg <= 32'h0000_0000;
      intr_tbl_reg <= 32'h0000_0000;
      sysproc_reg <= 32'h0000_0000;
      frame_ptr_reg <= 32'h0000_0000;
      stack_ptr_reg <= 32'h0000_0000;
      rcache_cfg_reg <= 32'h0000_0000;
      nmi_vec_reg <= 32'h0000_0000;
      sup_stack_reg <= 32'h0000_0000;
    end else if (rsp_ok && state_reg == S_PRCB) begin
      case (idx_reg)
        PRCB_FAULT_TBL: fault_tbl_reg <= mem_rsp_i.data;
        PRCB_CTL_TBL: ctl_tbl_reg <= mem_rsp_i.data;
        PRCB_ARITH: arith_reg <= mem_rsp_i.data;
        PRCB_FAULT_CFG: fault_cfg_reg <= mem_rsp_i.data;
        PRCB_INTR_TBL: intr_tbl_reg <= mem_rsp_i.data;
        PRCB_SYSPROC: sysproc_reg <= mem_rsp_i.data;
        PRCB_ISTACK: begin
          frame_ptr_reg <= mem_rsp_i.data;
          stack_ptr_reg <= mem_rsp_i.data + SP_OFFSET;
        end
        PRCB_RCACHE: rcache_cfg_reg <= mem_rsp_i.data;
        default: begin
        end
      endcase
    end else if (rsp_ok && state_reg == S_NMI) begin
      nmi_vec_reg <= mem_rsp_i.data;
    end else if (rsp_ok && state_reg == S_SSP) begin
      sup_stack_reg <= mem_rsp_i.data;
    end
  end

  // Load from the control block wins over an enabling command
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      icache_off_reg <= 1'b0;
    end else if (rsp_ok && state_reg == S_PRCB
                 && idx_reg == PRCB_ICACHE) begin
      icache_off_reg <= mem_rsp_i.data[ICACHE_OFF_BIT];
    end else if (icache_on_req) begin
      icache_off_reg <= 1'b0;
    end
  end

  // Register set cache occupancy; a call when full spills the oldest
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || state_reg == S_START) begin
      occ_reg <= 4'h0;
      spill_reg <= 1'b0;
    end else begin
      spill_reg <= call_i && !ret_i && (occ_reg >= rc_sets);
      if (call_i && !ret_i && occ_reg < rc_sets) begin
        occ_reg <= occ_reg + 4'h1;
      end else if (ret_i && !call_i && occ_reg != 4'h0) begin
        occ_reg <= occ_reg - 4'h1;
      end
    end
  end

  // AHB-Lite slave, zero wait states
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ahb_wr_reg <= 1'b0;
      ahb_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      ahb_wr_reg <= ahb_go && hwrite_i;
      if (ahb_go) begin
        ahb_addr_reg <= haddr_i[7:0];
      end
      if (ahb_go && !hwrite_i) begin
        hrdata_reg <= rd_word;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reinit_prcb_reg <= 32'h0000_0000;
    end else if (ahb_wr_reg && ahb_addr_reg == REG_REINIT_PRCB) begin
      reinit_prcb_reg <= hwdata_i;
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_DONE] = (state_reg == S_READY);
    status_word[ST_HALT] = (state_reg == S_HALT);
    status_word[ST_ISOL] = isolate_reg;
    status_word[ST_ITEST] = test_en_reg;
    status_word[ST_TBL_VALID] = tbl_valid_reg;
    status_word[ST_ICOFF] = icache_off_reg;
  end

  always_comb begin
    if (haddr_i[7:0] == REG_REINIT_PRCB) begin
      rd_word = reinit_prcb_reg;
    end else if (haddr_i[7:0] == REG_STATUS) begin
      rd_word = status_word;
    end else if (haddr_i[7:0] == REG_REGION0) begin
      rd_word = region0_reg;
    end else if (haddr_i[7:0] == REG_BUS_GLOBAL) begin
      rd_word = bus_global_reg;
    end else if (haddr_i[7:0] == REG_FIRST_IP) begin
      rd_word = first_ip_reg;
    end else if (haddr_i[7:0] == REG_PRCB_PTR) begin
      rd_word = prcb_ptr_reg;
    end else if (haddr_i[7:0] == REG_ARITH) begin
      rd_word = arith_reg;
    end else if (haddr_i[7:0] == REG_FRAME_PTR) begin
      rd_word = frame_ptr_reg;
    end else if (haddr_i[7:0] == REG_STACK_PTR) begin
      rd_word = stack_ptr_reg;
    end else if (haddr_i[7:0] == REG_NMI_VEC) begin
      rd_word = nmi_vec_reg;
    end else if (haddr_i[7:0] == REG_SUP_STACK) begin
      rd_word = sup_stack_reg;
    end else begin
      rd_word = 32'h0000_0000;
    end
  end

  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign fail_n_o = fail_n_reg;
  assign fail_oe_o = !isolate_reg;
  assign bus_oe_o = !isolate_reg;
  assign spill_o = spill_reg;
  assign region0_bus_config_o = region0_reg;
  assign region_table_valid_o = tbl_valid_reg;
  assign unaligned_fault_en_o = !fault_cfg_reg[UNALIGNED_OK_BIT];
  assign icache_disable_o = icache_off_reg;
  assign arith_ctl_image_o = arith_reg;
  assign reg_cache_sets_o = rc_sets;
  assign reg_cache_in_ram_o = (rc_sets > RCACHE_FREE_SETS);
  assign init_done_o = (state_reg == S_READY);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence ibr_word(logic [4:0] n);
    state_reg == S_IBR && rsp_ok && idx_reg == n;
  endsequence
  sequence ibr_final_sum(logic pass);
    ibr_word(IBR_LAST_IDX) ##0 ((sum_next == 32'h0000_0000) == pass);
  endsequence

  strap_latch_a: assert property ($rose(rst_n_i) |->
    isolate_reg == !$past(isolate_n_i)) else $error("isolation strap lost");
  test_latch_a: assert property ($rose(rst_n_i) |->
    test_en_reg == $past(internal_test_enable_i))
    else $error("self-test strap lost");
  pins_float_a: assert property (isolate_reg |->
    !fail_oe_o && !bus_oe_o && !mem_req_o.valid)
    else $error("pin driven while isolated");
  ibr_addr_a: assert property (state_reg == S_IBR |->
    mem_req_o.addr[31:6] == IBR_BASE[31:6]) else $error("bad record address");
  rsvd_skip_a: assert property (state_reg == S_IBR |->
    mem_req_o.addr != IBR_BASE + {25'h0, IBR_RSVD_IDX, 2'b00})
    else $error("reserved word fetched");
  relaxed_cfg_a: assert property (state_reg == S_START |=>
    region0_reg == MC_RELAXED && !tbl_valid_reg)
    else $error("no relaxed preset");
  cfg_byte0_a: assert property (ibr_word(5'h00) |=>
    region0_reg[7:0] == $past(mem_rsp_i.data[7:0]))
    else $error("first config byte not applied");
  region0_use_a: assert property (!tbl_valid_reg && mem_req_o.valid
    |->
    mem_req_o.bus_cfg == region0_reg) else $error("region table used early");
  sum_pass_a: assert property (ibr_final_sum(1'b1) |=>
    state_reg == S_PRCB && fail_n_o) else $error("passing sum refused");
  sum_fail_a: assert property (ibr_final_sum(1'b0) |=>
    (state_reg == S_HALT && !fail_n_o) [*3]) else $error("failing sum passed");
  fetch_order_a: assert property (ibr_word(IBR_IP_IDX) |=>
    idx_reg == IBR_PRCB_IDX) else $error("record order broken");
  icache_load_a: assert property (state_reg == S_PRCB && rsp_ok
    && idx_reg == PRCB_ICACHE |=>
    icache_disable_o == $past(mem_rsp_i.data[ICACHE_OFF_BIT]))
    else $error("cache disable bit not taken");
  spill_full_a: assert property (call_i && !ret_i && occ_reg >= rc_sets
    |=> spill_o && occ_reg == $past(occ_reg)) else $error("no spill when full");

endmodule

// ===== test/boot_config_loader_tb_top.sv
`timescale 1ns/1ps
module boot_config_loader_tb_top;
  import boot_cfg_pkg::*;
  logic clk_i = 0, rst_n_i = 0, iso_n = 1, te = 0, call = 0, hw = 0, bad = 0;
  logic [1:0] ht = 0;
  logic [7:0] ha = 0;
  logic [3:0] dly = 0, sets;
  logic [31:0] hwd = 0, rd, r0, arith, hrd;
  logic fail_n, fail_oe, bus_oe, spill, tvalid, ua, icd, inram, done, hrdy;
  logic hresp, ret = 0;
  int err_total = 0, n_checks = 0, sp;
  logic [31:0] fq[$], cq[$];
  mem_req_s req;
  mem_rsp_s rsp;
  always #4 clk_i = ~clk_i;
  boot_config_loader dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .isolate_n_i(iso_n), .internal_test_enable_i(te), .fail_n_o(fail_n),
    .fail_oe_o(fail_oe), .bus_oe_o(bus_oe), .mem_req_o(req),
    .mem_rsp_i(rsp), .call_i(call), .ret_i(ret), .spill_o(spill),
    .region0_bus_config_o(r0), .region_table_valid_o(tvalid),
    .unaligned_fault_en_o(ua), .icache_disable_o(icd),
    .arith_ctl_image_o(arith), .reg_cache_sets_o(sets),
    .reg_cache_in_ram_o(inram), .init_done_o(done), .hsel_i(1'b1),
    .haddr_i({24'h00_0000, ha}), .htrans_i(ht), .hwrite_i(hw),
    .hsize_i(3'h2), .hwdata_i(hwd), .hready_i(hrdy), .hrdata_o(hrd),
    .hreadyout_o(hrdy), .hresp_o(hresp));
  boot_rom_model rom (.clk_i(clk_i), .delay_i(dly), .bad_i(bad),
    .req_i(req), .rsp_o(rsp));
  always @(posedge clk_i) if (req.valid && rsp.valid) begin
    fq.push_back(req.addr);
    cq.push_back(req.bus_cfg);
  end
  task automatic chk(input string n, input logic [31:0] e, s);
    n_checks++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input [31:0] d);
    ht <= 2'h2;
    ha <= a;
    hw <= w;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    ht <= 2'h0;
    hwd <= d;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    rd = hrd;
    chk("hresp", 0, hresp);
  endtask
  task automatic boot(input logic i, t);
    rst_n_i <= 0;
    iso_n <= i;
    te <= t;
    repeat (4) @(posedge clk_i);
    fq.delete();
    cq.delete();
    rst_n_i <= 1;
    @(posedge clk_i);
  endtask
  task automatic wait_done(input logic v);
    int k = 0;
    while (done !== v && k < 3000) begin
      @(negedge clk_i);
      k++;
    end
    @(posedge clk_i);
    chk("done", v, done);
  endtask
  task automatic t_boot;
    boot(1, 0);
    wait_done(1);
    chk("cfg0", 32'h0007_FFF8, cq[0]);
    chk("cfg1", 32'h0000_0008, cq[1] & 32'h0000_00FF);
    for (int n = 0; n < 11; n++)
      chk("adr", IBR_BASE + 4 * (n > 3 ? n + 1 : n), fq[n]);
    chk("r0", 32'h0003_1208, r0);
    chk("tvalid", 1, tvalid);
    chk("ua", 0, ua);
    chk("icd", 1, icd);
    chk("arith", 32'h0000_1000, arith);
    chk("sets", 5'h17, {inram, sets});
    chk("fail", 1, fail_n);
    ahb(0, REG_FIRST_IP, 0);
    chk("ip", 32'h0000_1000, rd);
    ahb(0, REG_STACK_PTR, 0);
    chk("sp", 32'h0000_5040, rd);
    ahb(0, 8'h3C, 0);
    chk("unmapped", 0, rd);
    $display("test boot end");
  endtask
  task automatic t_cache;
    sp = 0;
    for (int i = 0; i < 11; i++) begin
      call <= (i != 8);
      ret <= (i == 8);
      @(posedge clk_i);
      call <= 0;
      ret <= 0;
      @(negedge clk_i);
      sp += (spill === 1'b1);
      @(posedge clk_i);
    end
    chk("spills", 2, sp);
    ahb(1, REG_CTRL, 32'h0000_0002);
    repeat (2) @(posedge clk_i);
    chk("icon", 0, icd);
    ahb(1, REG_REINIT_PRCB, 32'h0000_2000);
    ahb(1, REG_CTRL, 32'h0000_0001);
    wait_done(0);
    wait_done(1);
    chk("icre", 1, icd);
    ahb(0, REG_PRCB_PTR, 0);
    chk("prcb", 32'h0000_2000, rd);
    $display("test cache end");
  endtask
  task automatic t_bad;
    dly <= 3;
    bad <= 1;
    boot(1, 0);
    repeat (300) @(posedge clk_i);
    chk("hfail", 0, fail_n);
    ahb(0, REG_STATUS, 0);
    chk("halted", 32'h0000_0002, rd & 32'h0000_0003);
    bad <= 0;
    $display("test bad end");
  endtask
  task automatic t_test;
    boot(1, 1);
    repeat (30) @(posedge clk_i);
    chk("tfail", 0, fail_n);
    chk("tnofetch", 0, fq.size());
    wait_done(1);
    chk("tpass", 1, fail_n);
    $display("test selftest end");
  endtask
  task automatic t_iso;
    boot(0, 0);
    repeat (40) @(posedge clk_i);
    chk("oe", 0, {bus_oe, fail_oe});
    chk("inofetch", 0, fq.size());
    boot(1, 0);
    wait_done(1);
    chk("oe2", 3, {bus_oe, fail_oe});
    $display("test isolate end");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    t_boot();
    t_cache();
    t_bad();
    t_test();
    t_iso();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    print_verdict();
  end
endmodule

// ===== test/boot_rom_model.sv
`timescale 1ns/1ps
module boot_rom_model (
  input wire logic clk_i,
  input wire logic [3:0] delay_i,
  input wire logic bad_i,
  input wire boot_cfg_pkg::mem_req_s req_i,
  output boot_cfg_pkg::mem_rsp_s rsp_o
);
  import boot_cfg_pkg::*;
  logic [3:0] cnt = 4'h0;
  logic [31:0] last = 32'h0000_0000;
  logic v;
  function automatic logic [31:0] rom(input logic [31:0] a, input logic b);
    case (a)
      32'hFFFF_FF00: return 32'hAAAA_AA08;
      32'hFFFF_FF04: return 32'h0000_0012;
      32'hFFFF_FF08: return 32'h0000_0003;
      32'hFFFF_FF0C: return 32'h0000_1000;
      32'hFFFF_FF14: return 32'h0000_2000;
      32'hFFFF_FF2C: return b ? 32'h0000_0000 : 32'hFFFF_D001;
      32'h0000_2004: return 32'h0000_3000;
      32'h0000_2008: return 32'h0000_1000;
      32'h0000_200C: return 32'h4000_0001;
      32'h0000_201C: return 32'h0000_5000;
      32'h0000_2020: return 32'h0001_0000;
      32'h0000_2024: return 32'h0000_0007;
      32'h0000_3040: return 32'h0000_0001;
      default: return 32'h0000_0000;
    endcase
  endfunction
  assign v = req_i.valid && cnt == delay_i;
  // Idle data shows the inverse of the last word, never a stale copy
  assign rsp_o = {v, v ? rom(req_i.addr, bad_i) : ~last};
  always @(posedge clk_i) begin
    if (v) begin
      cnt <= 4'h0;
      last <= rom(req_i.addr, bad_i);
    end else if (req_i.valid) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
